// file: rfg_pkg.sv
package rfg_pkg;

  // one error flag per reason code; index equals the encoded reason value
  localparam int ERR_W = 27;

  localparam logic [7:0] ACT_RETRY = 8'h01;
  localparam logic [7:0] ACT_NO_RETRY = 8'h02;
  localparam logic [7:0] RSN_NONE = 8'h00;
  localparam logic [7:0] RSN_VENDOR = 8'hff;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // reasons each kind of port may report (both + own column)
  localparam logic [ERR_W-1:0] ERR_FABRIC_MASK = 27'h44800fe;
  localparam logic [ERR_W-1:0] ERR_NPORT_MASK = 27'h3dfffe6;
  // reasons that are retryable once the condition is corrected
  localparam logic [ERR_W-1:0] ERR_ACTION1_MASK = 27'h1c0003e;
  // reasons allowed against a link control frame
  localparam logic [ERR_W-1:0] ERR_FABRIC_LC_MASK = 27'h040003e;
  localparam logic [ERR_W-1:0] ERR_NPORT_LC_MASK = 27'h0100000;

  localparam int FCTL_XCHG_CTX_BIT = 23;
  localparam int FCTL_SEQ_CTX_BIT = 22;

  localparam logic [7:0] HDR_TYPE_ZERO = 8'h00;
  localparam logic [7:0] HDR_DFCTL_ZERO = 8'h00;

  typedef enum logic [2:0] {
    SOF_C1, SOF_I1, SOF_N1, SOF_I2, SOF_N2, SOF_I3, SOF_N3, SOF_F
  } rfg_sof_type;

  typedef enum logic [2:0] {
    EOF_N, EOF_T, EOF_DT, EOF_A, EOF_NI, EOF_DTI, EOF_F
  } rfg_eof_type;

  typedef struct packed {
    logic [7:0] action;
    logic [7:0] reason;
    logic [7:0] rsvd;
    logic [7:0] vendor;
  } rfg_param_type;

  typedef struct packed {
    logic [7:0] r_ctl;
    logic [23:0] d_id;
    logic [7:0] type_f;
    logic [23:0] s_id;
    logic [23:0] f_ctl;
    logic [7:0] seq_id;
    logic [7:0] df_ctl;
    logic [15:0] seq_cnt;
    logic [15:0] ox_id;
    logic [15:0] rx_id;
    logic [31:0] param;
  } rfg_hdr_type;

  typedef struct packed {
    rfg_hdr_type hdr;
    rfg_sof_type sof;
    rfg_eof_type eof;
    logic link_ctl;
    logic is_reject;
    logic frame_ok;
    logic xchg_ok;
    logic xid_assign;
  } rfg_rx_type;

  typedef struct packed {
    rfg_hdr_type hdr;
    rfg_eof_type eof;
  } rfg_rjt_type;

endpackage

// file: rfg_reason_pick.sv
`timescale 1ns/1ps
module rfg_reason_pick
  import rfg_pkg::*;
(
  input wire logic [ERR_W-1:0] i_err,
  input wire logic i_err_vendor,
  input wire logic i_fabric,
  input wire logic i_link_ctl,
  output logic o_found,
  output logic o_lc_ok,
  output logic [7:0] o_reason,
  output logic [7:0] o_action
);

  logic [ERR_W-1:0] avail;
  logic [ERR_W-1:0] lc_mask;
  logic [ERR_W-1:0] hit;

  assign avail = i_err & (i_fabric ? ERR_FABRIC_MASK : ERR_NPORT_MASK);
  assign lc_mask = i_fabric ? ERR_FABRIC_LC_MASK : ERR_NPORT_LC_MASK;

  // lowest reason code wins; vendor unique is checked last
  always_comb begin
    o_found = 1'b0;
    o_reason = RSN_NONE;
    hit = '0;
    for (int k = ERR_W - 1; k >= 1; k--) begin
      if (avail[k]) begin
        o_found = 1'b1;
        o_reason = 8'(k);
        hit = '0;
        hit[k] = 1'b1;
      end
    end
    if (!o_found && i_err_vendor) begin
      o_found = 1'b1;
      o_reason = RSN_VENDOR;
    end
  end

  // vendor errors never count as allowed against link control frames
  assign o_lc_ok = i_link_ctl && |(hit & lc_mask);
  assign o_action = (|(hit & ERR_ACTION1_MASK)) ? ACT_RETRY : ACT_NO_RETRY;

endmodule

// file: rfg_reject_gen.sv
`timescale 1ns/1ps
module rfg_reject_gen
  import rfg_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter logic [7:0] RCTL_PORT_RJT = 8'h00,
  parameter logic [7:0] RCTL_FABRIC_RJT = 8'h01
)(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_fabric,
  input wire logic i_frm_valid,
  output logic o_frm_ready,
  input wire rfg_rx_type i_frm,
  input wire logic [ERR_W-1:0] i_err,
  input wire logic i_err_vendor,
  input wire logic [7:0] i_vendor_qual,
  output logic o_rjt_valid,
  input wire logic i_rjt_ready,
  output rfg_rjt_type o_rjt,
  output logic o_abort_seq,
  output logic o_discard,
  output logic o_seq_abnormal,
  output logic o_peer_term,
  output logic o_peer_abort,
  output logic [CNT_W-1:0] o_rjt_cnt,
  output logic [CNT_W-1:0] o_discard_cnt,
  output logic [CNT_W-1:0] o_abort_cnt
);

  logic err_found;
  logic lc_ok;
  logic [7:0] err_reason;
  logic [7:0] err_action;
  logic take;
  logic class12;
  logic dec_reject;
  logic dec_abort;
  logic dec_discard;
  logic dec_peer_term;
  logic dec_peer_abort;
  rfg_eof_type rjt_eof;
  rfg_param_type rjt_param;
  rfg_hdr_type rjt_hdr;

  logic rjt_valid_q;
  rfg_rjt_type rjt_q;
  logic abort_q;
  logic discard_q;
  logic seq_abn_q;
  logic peer_term_q;
  logic peer_abort_q;
  logic [CNT_W-1:0] rjt_cnt_q;
  logic [CNT_W-1:0] discard_cnt_q;
  logic [CNT_W-1:0] abort_cnt_q;

  rfg_reason_pick u_pick (
    .i_err(i_err),
    .i_err_vendor(i_err_vendor),
    .i_fabric(i_fabric),
    .i_link_ctl(i_frm.link_ctl),
    .o_found(err_found),
    .o_lc_ok(lc_ok),
    .o_reason(err_reason),
    .o_action(err_action)
  );

  // one reject is held at a time; a new frame waits until it has left
  assign o_frm_ready = !rjt_valid_q;
  assign take = i_ce && i_frm_valid && o_frm_ready;

  always_comb begin
    unique case (i_frm.sof)
      SOF_C1, SOF_I1, SOF_N1, SOF_I2, SOF_N2: class12 = 1'b1;
      SOF_I3, SOF_N3, SOF_F: class12 = 1'b0;
    endcase
  end

  // frame disposition
  always_comb begin
    dec_reject = 1'b0;
    dec_abort = 1'b0;
    dec_discard = 1'b0;
    dec_peer_term = 1'b0;
    dec_peer_abort = 1'b0;
    if (!i_frm.frame_ok) begin
      // invalid frames never get a reject, only dropped
      dec_discard = 1'b1;
    end else if (i_frm.is_reject) begin
      if (err_found) begin
        dec_discard = 1'b1;
      end else if (i_frm.eof == EOF_T || i_frm.eof == EOF_DT) begin
        dec_peer_term = 1'b1;
      end else if (i_frm.eof == EOF_N) begin
        dec_peer_abort = 1'b1;
      end
    end else if (err_found) begin
      if (!class12) begin
        dec_discard = 1'b1;
      end else if (i_frm.link_ctl && !lc_ok) begin
        if (!i_fabric && i_frm.xchg_ok) begin
          dec_abort = 1'b1;
        end else begin
          dec_discard = 1'b1;
        end
      end else begin
        dec_reject = 1'b1;
      end
    end
  end

  // end delimiter: terminate only where the frame allows it
  always_comb begin
    if (i_frm.link_ctl) begin
      rjt_eof = EOF_N;
    end else if (i_frm.sof == SOF_C1) begin
      rjt_eof = EOF_DT;
    end else if (!i_fabric && i_frm.sof == SOF_I2 && i_frm.xid_assign) begin
      rjt_eof = EOF_T;
    end else begin
      rjt_eof = EOF_N;
    end
  end

  always_comb begin
    rjt_param.action = err_action;
    rjt_param.reason = err_reason;
    rjt_param.rsvd = RSVD_BYTE;
    rjt_param.vendor = i_vendor_qual;
  end

  always_comb begin
    rjt_hdr = i_frm.hdr;
    rjt_hdr.r_ctl = i_fabric ? RCTL_FABRIC_RJT : RCTL_PORT_RJT;
    rjt_hdr.d_id = i_frm.hdr.s_id;
    rjt_hdr.s_id = i_frm.hdr.d_id;
    rjt_hdr.f_ctl[FCTL_XCHG_CTX_BIT] = ~i_frm.hdr.f_ctl[FCTL_XCHG_CTX_BIT];
    rjt_hdr.f_ctl[FCTL_SEQ_CTX_BIT] = ~i_frm.hdr.f_ctl[FCTL_SEQ_CTX_BIT];
    rjt_hdr.seq_id = i_frm.hdr.seq_id;
    rjt_hdr.seq_cnt = i_frm.hdr.seq_cnt;
    rjt_hdr.type_f = HDR_TYPE_ZERO;
    rjt_hdr.df_ctl = HDR_DFCTL_ZERO;
    rjt_hdr.param = rjt_param;
  end

  // outgoing reject holding register
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rjt_valid_q <= 1'b0;
    end else if (i_ce) begin
      if (take && dec_reject) begin
        rjt_valid_q <= 1'b1;
      end else if (rjt_valid_q && i_rjt_ready) begin
        rjt_valid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rjt_q <= '0;
    end else if (i_ce && take && dec_reject) begin
      rjt_q.hdr <= rjt_hdr;
      rjt_q.eof <= rjt_eof;
    end
  end

  // one-cycle event pulses; with i_ce low they hold, so a pulse may stand longer
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      abort_q <= 1'b0;
    end else if (i_ce) begin
      abort_q <= take && dec_abort;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      discard_q <= 1'b0;
    end else if (i_ce) begin
      discard_q <= take && dec_discard;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      peer_term_q <= 1'b0;
    end else if (i_ce) begin
      peer_term_q <= take && dec_peer_term;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      peer_abort_q <= 1'b0;
    end else if (i_ce) begin
      peer_abort_q <= take && dec_peer_abort;
    end
  end

  // a rejected data frame takes its sequence down on this end too
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      seq_abn_q <= 1'b0;
    end else if (i_ce) begin
      seq_abn_q <= take && dec_reject && !i_frm.link_ctl;
    end
  end

  // counters wrap; software-free block, so they are for debug visibility only
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rjt_cnt_q <= '0;
    end else if (i_ce && take && dec_reject) begin
      rjt_cnt_q <= rjt_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      discard_cnt_q <= '0;
    end else if (i_ce && take && dec_discard) begin
      discard_cnt_q <= discard_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      abort_cnt_q <= '0;
    end else if (i_ce && take && dec_abort) begin
      abort_cnt_q <= abort_cnt_q + 1'b1;
    end
  end

  assign o_rjt_valid = rjt_valid_q;
  assign o_rjt = rjt_q;
  assign o_abort_seq = abort_q;
  assign o_discard = discard_q;
  assign o_seq_abnormal = seq_abn_q;
  assign o_peer_term = peer_term_q;
  assign o_peer_abort = peer_abort_q;
  assign o_rjt_cnt = rjt_cnt_q;
  assign o_discard_cnt = discard_cnt_q;
  assign o_abort_cnt = abort_cnt_q;

endmodule

// file: rfg_reject_gen_sva.sv
`timescale 1ns/1ps
module rfg_reject_gen_sva
  import rfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_fabric,
  input wire logic i_frm_valid,
  input wire logic o_frm_ready,
  input wire rfg_rx_type i_frm,
  input wire logic o_rjt_valid,
  input wire logic i_rjt_ready,
  input wire rfg_rjt_type o_rjt,
  input wire logic o_discard
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  wire tk = i_ce & i_frm_valid & o_frm_ready;
  a_ready_blocks: assert property (o_frm_ready == !o_rjt_valid) else $error("ready while busy");
  a_rjt_held: assert property (o_rjt_valid && !i_rjt_ready |=> o_rjt_valid && $stable(o_rjt))
    else $error("reject not held");
  a_bad_dropped: assert property (tk && !i_frm.frame_ok |=> o_discard && !o_rjt_valid)
    else $error("invalid frame answered");
  a_class3_quiet: assert property (tk && i_frm.sof inside {SOF_I3, SOF_N3} |=> !o_rjt_valid)
    else $error("class 3 rejected");
  a_rjt_no_rjt: assert property (tk && i_frm.is_reject |=> !o_rjt_valid)
    else $error("reject answered");
  a_id_swap: assert property ($rose(o_rjt_valid) |-> o_rjt.hdr.d_id == $past(i_frm.hdr.s_id)
    && o_rjt.hdr.s_id == $past(i_frm.hdr.d_id)) else $error("ids not swapped");
  a_fctl_inv: assert property ($rose(o_rjt_valid)
    |-> o_rjt.hdr.f_ctl == ($past(i_frm.hdr.f_ctl) ^ 24'hc00000)) else $error("f_ctl wrong");
  a_seq_copy: assert property ($rose(o_rjt_valid) |-> o_rjt.hdr.seq_id == $past(i_frm.hdr.seq_id)
    && o_rjt.hdr.seq_cnt == $past(i_frm.hdr.seq_cnt)) else $error("seq fields wrong");
  a_dt_only_c1: assert property ($rose(o_rjt_valid) && o_rjt.eof == EOF_DT
    |-> $past(i_frm.sof) == SOF_C1) else $error("EOFdt without SOFc1");
  a_nport_lc: assert property ($rose(o_rjt_valid) && $past(i_frm.link_ctl)
    && !$past(i_fabric) |-> o_rjt.hdr.param[31:16] == 16'h0214)
    else $error("bad link control reject");
  a_param_rsvd: assert property (o_rjt_valid |-> o_rjt.hdr.param[15:8] == 8'h00)
    else $error("reserved byte set");
endmodule

bind rfg_reject_gen rfg_reject_gen_sva rfg_reject_gen_sva_inst (
  .i_clk_sys(i_clk_sys),
  .i_rst(i_rst),
  .i_ce(i_ce),
  .i_fabric(i_fabric),
  .i_frm_valid(i_frm_valid),
  .o_frm_ready(o_frm_ready),
  .i_frm(i_frm),
  .o_rjt_valid(o_rjt_valid),
  .i_rjt_ready(i_rjt_ready),
  .o_rjt(o_rjt),
  .o_discard(o_discard)
);

// file: rfg_rjt_sink.sv
`timescale 1ns/1ps
module rfg_rjt_sink
  import rfg_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_rjt_valid,
  input wire rfg_rjt_type i_rjt,
  output logic o_rjt_ready,
  output logic o_abort_req
);
  logic [1:0] wait_q;
  // slow mode keeps ready low three cycles so the reject has to stand
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_rjt_valid) begin
      wait_q <= 2'h0;
    end else if (wait_q != 2'h3) begin
      wait_q <= wait_q + 2'h1;
    end
  end
  assign o_rjt_ready = !i_slow || wait_q == 2'h3;
  // open end means this side aborts; EOFt or EOFdt means already ended
  assign o_abort_req = i_rjt_valid && o_rjt_ready && i_rjt.eof == EOF_N;
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top
  import rfg_pkg::*;
;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_fabric = 1'b0, i_frm_valid = 1'b0;
  logic i_err_vendor = 1'b0, slow = 1'b0, o_frm_ready, o_rjt_valid, i_rjt_ready, o_abort_seq;
  logic o_discard, o_seq_abnormal, o_peer_term, o_peer_abort, abort_req;
  logic [7:0] i_vendor_qual = 8'h5a;
  logic [ERR_W-1:0] i_err = '0;
  logic [15:0] o_rjt_cnt, o_discard_cnt, o_abort_cnt, c0;
  rfg_rx_type i_frm = '0;
  rfg_rjt_type o_rjt;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  wire [5:0] st = {o_rjt_valid, o_seq_abnormal, o_discard, o_abort_seq, o_peer_term, o_peer_abort};
  rfg_reject_gen rfg_reject_gen_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_fabric(i_fabric),
    .i_frm_valid(i_frm_valid),
    .o_frm_ready(o_frm_ready),
    .i_frm(i_frm),
    .i_err(i_err),
    .i_err_vendor(i_err_vendor),
    .i_vendor_qual(i_vendor_qual),
    .o_rjt_valid(o_rjt_valid),
    .i_rjt_ready(i_rjt_ready),
    .o_rjt(o_rjt),
    .o_abort_seq(o_abort_seq),
    .o_discard(o_discard),
    .o_seq_abnormal(o_seq_abnormal),
    .o_peer_term(o_peer_term),
    .o_peer_abort(o_peer_abort),
    .o_rjt_cnt(o_rjt_cnt),
    .o_discard_cnt(o_discard_cnt),
    .o_abort_cnt(o_abort_cnt)
  );
  rfg_rjt_sink rfg_rjt_sink_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_slow(slow),
    .i_rjt_valid(o_rjt_valid), .i_rjt(o_rjt), .o_rjt_ready(i_rjt_ready), .o_abort_req(abort_req));
  always #12.5 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // holds the frame until taken; returns in the answer cycle with valid still up,
  // so the next call follows without a glitch on the strobe
  task automatic offer(input rfg_sof_type sf, input rfg_eof_type ef, input logic [4:0] fl,
    input int k);
    i_frm.sof = sf;
    i_frm.eof = ef;
    {i_frm.link_ctl, i_frm.is_reject, i_frm.frame_ok, i_frm.xchg_ok, i_frm.xid_assign} = fl;
    i_err = (k > 0) ? (27'h1 << k) : '0;
    i_frm_valid = 1'b1;
    while (o_frm_ready !== 1'b1) begin
      @(posedge i_clk_sys); #2;
    end
    @(posedge i_clk_sys); #2;
  endtask
  task automatic t_codes();
    logic ok;
    for (int f = 0; f < 2; f++) for (int k = 1; k < 27; k++) begin
      i_fabric = f[0];
      ok = k inside {1, 2, 5, 6, 7, 19, 22} ||
        (f ? k inside {3, 4, 26} : k inside {[8:18], 20, [23:25]});
      offer(SOF_N2, EOF_N, 5'b00110, k);
      chk(st, ok ? 6'h30 : 6'h00);
      if (ok) begin
        chk(o_rjt.hdr.param, {k inside {[1:5], [22:24]} ? 8'h01 : 8'h02, k[7:0], 8'h00, 8'h5a});
        chk(o_rjt.hdr.d_id, i_frm.hdr.s_id);
        chk(abort_req, 1'b1);
        chk(o_rjt.hdr.f_ctl, i_frm.hdr.f_ctl ^ 24'hc00000);
      end
    end
  endtask
  task automatic t_first();
    i_fabric = 1'b0;
    i_frm.hdr.seq_cnt = 16'h0008;
    i_err_vendor = 1'b1;
    offer(SOF_N1, EOF_N, 5'b00110, 9);
    chk(o_rjt.hdr.param[23:16], 8'h09);
    offer(SOF_N1, EOF_N, 5'b00110, 0);
    i_err_vendor = 1'b0;
    chk(o_rjt.hdr.param, {8'h02, 8'hff, 8'h00, 8'h5a});
    chk(o_rjt.hdr.seq_cnt, 16'h0008);
  endtask
  task automatic t_lc();
    i_fabric = 1'b1;
    c0 = o_abort_cnt;
    offer(SOF_N2, EOF_N, 5'b10110, 5);
    chk({st, o_rjt.hdr.param[31:16]}, {6'h20, 16'h0105});
    offer(SOF_N2, EOF_N, 5'b10110, 19);
    chk(st, 6'h08);
    i_fabric = 1'b0;
    offer(SOF_N2, EOF_N, 5'b10110, 20);
    chk({st, o_rjt.hdr.param[31:16]}, {6'h20, 16'h0214});
    offer(SOF_N2, EOF_N, 5'b10110, 9);
    chk(st, 6'h04);
    chk(o_abort_cnt, c0 + 16'h1);
    offer(SOF_N2, EOF_N, 5'b10100, 9);
    chk(st, 6'h08);
  endtask
  task automatic t_drop();
    c0 = o_discard_cnt;
    offer(SOF_N3, EOF_N, 5'b00110, 1);
    chk(st, 6'h08);
    offer(SOF_N2, EOF_N, 5'b01110, 1);
    chk(st, 6'h08);
    offer(SOF_N2, EOF_N, 5'b00010, 1);
    chk(st, 6'h08);
    offer(SOF_N2, EOF_T, 5'b01110, 0);
    chk(st, 6'h02);
    offer(SOF_N2, EOF_N, 5'b01110, 0);
    chk(st, 6'h01);
    offer(SOF_N2, EOF_DT, 5'b01110, 0);
    chk(st, 6'h02);
    chk(o_discard_cnt, c0 + 16'h3);
    offer(SOF_F, EOF_N, 5'b00110, 1);
    chk(st, 6'h08);
  endtask
  // a frozen block takes nothing and its last pulse stands until it runs again
  task automatic t_ce();
    offer(SOF_N3, EOF_N, 5'b00110, 1);
    i_ce = 1'b0;
    i_frm.sof = SOF_N2;
    repeat (2) @(posedge i_clk_sys);
    #2;
    chk(st, 6'h08);
    i_ce = 1'b1;
    @(posedge i_clk_sys);
    #2;
    chk(st, 6'h30);
  endtask
  task automatic t_eof();
    offer(SOF_C1, EOF_N, 5'b00110, 1);
    chk(o_rjt.eof, EOF_DT);
    chk(abort_req, 1'b0);
    offer(SOF_I2, EOF_N, 5'b00111, 1);
    chk(o_rjt.eof, EOF_T);
    offer(SOF_I2, EOF_N, 5'b00110, 1);
    chk(o_rjt.eof, EOF_N);
    i_fabric = 1'b1;
    offer(SOF_I2, EOF_N, 5'b00111, 1);
    chk(o_rjt.eof, EOF_N);
  endtask
  // second frame waits behind a stalled reject and must not be lost
  task automatic t_stall();
    slow = 1'b1;
    c0 = o_rjt_cnt;
    offer(SOF_N2, EOF_N, 5'b00110, 1);
    offer(SOF_N2, EOF_N, 5'b00110, 2);
    chk({o_rjt.hdr.param[23:16], o_rjt_cnt}, {8'h02, c0 + 16'h2});
    slow = 1'b0;
  endtask
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    i_frm.hdr.d_id = 24'h0a0b0c;
    i_frm.hdr.s_id = 24'h010203;
    i_frm.hdr.f_ctl = 24'h400a55;
    i_frm.hdr.seq_id = 8'h33;
    repeat (8) @(posedge i_clk_sys);
    #2;
    i_rst = 1'b0;
    t_codes();
    t_first();
    t_lc();
    t_drop();
    t_ce();
    t_eof();
    t_stall();
    final_report();
  end
endmodule
